// File: lnbsc_pkg.sv
// Constants, offsets and state types of the supply control logic
package lnbsc_pkg;
	// ----------------------------------------
	// Clock and oscillator
	// ----------------------------------------
	localparam longint CLK_HZ = 10_000_000;
	localparam longint TONE_HZ = 22_000;
	localparam longint SW_MULT = 20;
	localparam longint SW_HZ = TONE_HZ * SW_MULT;
	localparam int OSC_HALF = int'(CLK_HZ / (2 * SW_HZ));
	localparam int TONE_HALF = int'(SW_MULT / 2);
	localparam int OSC_W = 5;
	localparam int TONE_W = 4;
	// ----------------------------------------
	// Protection times in ns, counted in converter ticks
	// ----------------------------------------
	localparam longint NS_PER_S = 1_000_000_000;
	localparam longint T_OL_DLY_NS = 23_000;
	localparam longint T_BC_DLY_NS = 100_000;
	localparam longint T_BC_OFF_NS = 5_000_000;
	localparam longint T_ON_NS = 20_000_000;
	localparam longint T_OFF_NS = 900_000_000;
	localparam int OL_DLY_TICKS = int'((T_OL_DLY_NS * SW_HZ + NS_PER_S - 1)
		/ NS_PER_S);
	localparam int BC_DLY_TICKS = int'((T_BC_DLY_NS * SW_HZ + NS_PER_S - 1)
		/ NS_PER_S);
	localparam int BC_OFF_TICKS = int'((T_BC_OFF_NS * SW_HZ + NS_PER_S - 1)
		/ NS_PER_S);
	localparam int ON_TICKS = int'((T_ON_NS * SW_HZ + NS_PER_S - 1)
		/ NS_PER_S);
	localparam int OFF_TICKS = int'((T_OFF_NS * SW_HZ + NS_PER_S - 1)
		/ NS_PER_S);
	localparam int CNT_W = 20;
	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [3:0] REG_TONE = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hc;
	localparam int TONE_ON_POS = 0;
	localparam int EXT_PASS_POS = 1;
	localparam int LVL_LSB_POS = 0;
	localparam int LVL_MSB_POS = 1;
	localparam int RPD_POS = 2;
	localparam int STATIC_POS = 3;
	localparam int LOWER_POS = 0;
	localparam int UPPER_POS = 1;
	localparam int ENABLE_POS = 2;
	localparam int BC_POS = 0;
	localparam int OL_POS = 1;
	localparam int OT_POS = 2;
	localparam int RUN_POS = 3;
	localparam logic [3:0] CFG_RESET = 4'h0;
	// ----------------------------------------
	// Output voltage codes
	// ----------------------------------------
	localparam logic [1:0] VOUT_13V3 = 2'h0;
	localparam logic [1:0] VOUT_14V3 = 2'h1;
	localparam logic [1:0] VOUT_18V3 = 2'h2;
	localparam logic [1:0] VOUT_19V3 = 2'h3;
	// ----------------------------------------
	// State machines
	// ----------------------------------------
	typedef enum logic [1:0] {
		LNBSC_OL_NORM = 2'h0,
		LNBSC_OL_DLY = 2'h1,
		LNBSC_OL_OFF = 2'h3,
		LNBSC_OL_ON = 2'h2
	} lnbsc_ol_t;
	typedef enum logic [1:0] {
		LNBSC_BC_NORM = 2'h0,
		LNBSC_BC_DLY = 2'h1,
		LNBSC_BC_OFF = 2'h3
	} lnbsc_bc_t;
endpackage

// File: lnbsc_osc.sv
// Tone oscillator: converter clock at twenty times the tone
`timescale 1ns/1ns
module lnbsc_osc (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic hold,
	// Oscillator outputs
	output logic sw_clk,
	output logic sw_tick,
	output logic tone
);
	import lnbsc_pkg::*;

	logic [OSC_W-1:0] div_cnt;
	logic [TONE_W-1:0] tone_cnt;
	wire div_end = (div_cnt == OSC_W'(OSC_HALF - 1));
	wire tone_end = (tone_cnt == TONE_W'(TONE_HALF - 1));

	// Held in reset while the supply is low
	always_ff @(posedge ref_clk) begin
		if (!nrst || hold) begin
			div_cnt <= '0;
			tone_cnt <= '0;
			sw_clk <= 1'b0;
			sw_tick <= 1'b0;
			tone <= 1'b0;
		end else begin
			div_cnt <= div_end ? '0 : div_cnt + 1'b1;
			sw_clk <= div_end ? !sw_clk : sw_clk;
			sw_tick <= div_end && !sw_clk;
			if (sw_tick) begin
				tone_cnt <= tone_end ? '0 : tone_cnt + 1'b1;
				tone <= tone_end ? !tone : tone;
			end
		end
	end
endmodule // lnbsc_osc

// File: lnbsc_ctrl.sv
// Control logic of the single-output supply regulator
`timescale 1ns/1ns
module lnbsc_ctrl #(
	parameter int OFF_T = lnbsc_pkg::OFF_TICKS,
	parameter int ON_T = lnbsc_pkg::ON_TICKS,
	parameter int BC_OFF_T = lnbsc_pkg::BC_OFF_TICKS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Pins and sense inputs
	input wire logic uvlo,
	input wire logic tone_modulation_input,
	input wire logic detector_threshold_select,
	input wire logic tone_detector_input,
	input wire logic tone_over_tx_level,
	input wire logic range_select_pin,
	input wire logic overload_sense,
	input wire logic clamp_sense,
	input wire logic back_current_sense,
	input wire logic over_temp_sense,
	input wire logic cooled_sense,
	input wire logic serial_reset,
	// Power stage control
	output logic sw_clk,
	output logic converter_en,
	output logic linreg_en,
	output logic current_limited,
	output logic dynamic_limit_en,
	output logic [1:0] limit_level,
	output logic [1:0] vout_code,
	output logic tone_out,
	// Open-drain pins
	output logic tone_detected_n,
	output logic tone_detected_oe,
	output logic fault_indicator_n,
	output logic fault_indicator_oe
);
	import lnbsc_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NPIN = 11;
	wire [NPIN-1:0] pin_raw = {uvlo, tone_modulation_input,
		detector_threshold_select, tone_detector_input,
		tone_over_tx_level, range_select_pin, overload_sense,
		clamp_sense, back_current_sense, over_temp_sense, serial_reset};
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	logic cool1;
	logic cool2;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					sync1[gi] <= gi == NPIN - 1;
					sync2[gi] <= gi == NPIN - 1;
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		cool1 <= nrst ? cooled_sense : 1'b0;
		cool2 <= nrst ? cool1 : 1'b0;
	end

	wire uvlo_s = sync2[10];
	wire mod_s = sync2[9];
	wire thr_s = sync2[8];
	wire det_rx_s = sync2[7];
	wire det_tx_s = sync2[6];
	wire range_s = sync2[5];
	wire ovl_s = sync2[4];
	wire clamp_s = sync2[3];
	wire bc_s = sync2[2];
	wire ot_s = sync2[1];
	wire sreset_s = sync2[0];

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [1:0] cfg_tone;
	logic [3:0] cfg_cmd;
	logic [2:0] cfg_ctrl;
	logic ot_flag;
	logic ol_flag;
	logic bc_flag;

	wire tone_on_bit = cfg_tone[TONE_ON_POS];
	wire ext_tone_pass_select = cfg_tone[EXT_PASS_POS];
	wire limit_level_lsb = cfg_cmd[LVL_LSB_POS];
	wire limit_level_msb = cfg_cmd[LVL_MSB_POS];
	wire range_pin_disable_bit = cfg_cmd[RPD_POS];
	wire static_limit_select_bit = cfg_cmd[STATIC_POS];
	wire lower_range_step_bit = cfg_ctrl[LOWER_POS];
	wire upper_range_step_bit = cfg_ctrl[UPPER_POS];
	wire enable_bit = cfg_ctrl[ENABLE_POS];

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// One wait cycle keeps read data coming from a flip-flop
	wire bus_req = read || write;
	wire bus_take = bus_req && !waitrequest;
	wire wr_take = write && !waitrequest;
	wire hit_tone = (address == REG_TONE);
	wire hit_cmd = (address == REG_CMD);
	wire hit_ctrl = (address == REG_CTRL);
	wire hit_stat = (address == REG_STAT);
	wire alive = !uvlo_s && enable_bit;
	wire [31:0] stat_word = {28'h0, converter_en, ot_flag, ol_flag, bc_flag};
	logic [31:0] next_readdata;

	always_comb begin
		if (hit_tone) begin
			next_readdata = {30'h0, cfg_tone};
		end else if (hit_cmd) begin
			next_readdata = {28'h0, cfg_cmd};
		end else if (hit_ctrl) begin
			next_readdata = {29'h0, cfg_ctrl};
		end else if (hit_stat) begin
			next_readdata = stat_word;
		end else begin
			next_readdata = 32'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0;
		end else begin
			waitrequest <= !(bus_req && waitrequest);
			readdata <= (read && waitrequest) ? next_readdata : readdata;
		end
	end

	// Heat or lockout wipes what the host wrote
	always_ff @(posedge ref_clk) begin
		if (!nrst || uvlo_s || ot_s) begin
			cfg_tone <= CFG_RESET[1:0];
			cfg_cmd <= CFG_RESET;
			cfg_ctrl <= CFG_RESET[2:0];
		end else if (wr_take) begin
			cfg_tone <= hit_tone ? writedata[1:0] : cfg_tone;
			cfg_cmd <= hit_cmd ? writedata[3:0] : cfg_cmd;
			cfg_ctrl <= hit_ctrl ? writedata[2:0] : cfg_ctrl;
		end
	end

	// ----------------------------------------
	// Oscillator
	// ----------------------------------------
	logic sw_tick;
	logic int_tone;
	logic osc_clk;

	lnbsc_osc u_osc (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.hold(uvlo_s),
		.sw_clk(osc_clk),
		.sw_tick(sw_tick),
		.tone(int_tone)
	);

	// ----------------------------------------
	// Dynamic overload sequencer
	// ----------------------------------------
	lnbsc_ol_t ol_state;
	lnbsc_ol_t next_ol_state;
	logic [CNT_W-1:0] ol_cnt;
	logic [CNT_W-1:0] next_ol_cnt;
	logic ol_seen;
	wire ol_dly_end = (ol_cnt == CNT_W'(OL_DLY_TICKS - 1));
	wire ol_off_end = (ol_cnt == CNT_W'(OFF_T - 1));
	wire ol_on_end = (ol_cnt == CNT_W'(ON_T - 1));
	wire [CNT_W-1:0] ol_inc = ol_cnt + 1'b1;

	always_comb begin
		next_ol_state = ol_state;
		next_ol_cnt = ol_cnt;
		if (!alive || static_limit_select_bit) begin
			next_ol_state = LNBSC_OL_NORM;
			next_ol_cnt = '0;
		end else begin
			case (ol_state)
			LNBSC_OL_NORM: begin
				next_ol_cnt = '0;
				if (ovl_s) begin
					next_ol_state = LNBSC_OL_DLY;
				end
			end
			LNBSC_OL_DLY: begin
				if (!ovl_s) begin
					next_ol_state = LNBSC_OL_NORM;
				end else if (sw_tick) begin
					next_ol_cnt = ol_dly_end ? '0 : ol_inc;
					if (ol_dly_end) begin
						next_ol_state = LNBSC_OL_OFF;
					end
				end
			end
			LNBSC_OL_OFF: begin
				if (sw_tick) begin
					next_ol_cnt = ol_off_end ? '0 : ol_inc;
					if (ol_off_end) begin
						next_ol_state = LNBSC_OL_ON;
					end
				end
			end
			LNBSC_OL_ON: begin
				if (sw_tick) begin
					next_ol_cnt = ol_on_end ? '0 : ol_inc;
					if (ol_on_end) begin
						next_ol_state = (ol_seen || ovl_s) ?
							LNBSC_OL_OFF : LNBSC_OL_NORM;
					end
				end
			end
			default: begin
				next_ol_state = LNBSC_OL_NORM;
				next_ol_cnt = '0;
			end
			endcase
		end
	end

	// Counter only moves on oscillator ticks
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ol_state <= LNBSC_OL_NORM;
			ol_cnt <= '0;
			ol_seen <= 1'b0;
		end else begin
			ol_state <= next_ol_state;
			ol_cnt <= next_ol_cnt;
			ol_seen <= (ol_state == LNBSC_OL_ON) && (ol_seen || ovl_s);
		end
	end

	// ----------------------------------------
	// Back-current sequencer
	// ----------------------------------------
	lnbsc_bc_t bc_state;
	lnbsc_bc_t next_bc_state;
	logic [CNT_W-1:0] bc_cnt;
	logic [CNT_W-1:0] next_bc_cnt;
	wire bc_dly_end = (bc_cnt == CNT_W'(BC_DLY_TICKS - 1));
	wire bc_off_end = (bc_cnt == CNT_W'(BC_OFF_T - 1));
	wire [CNT_W-1:0] bc_inc = bc_cnt + 1'b1;

	always_comb begin
		next_bc_state = bc_state;
		next_bc_cnt = bc_cnt;
		if (!alive) begin
			next_bc_state = LNBSC_BC_NORM;
			next_bc_cnt = '0;
		end else begin
			case (bc_state)
			LNBSC_BC_NORM: begin
				next_bc_cnt = '0;
				if (bc_s) begin
					next_bc_state = LNBSC_BC_DLY;
				end
			end
			LNBSC_BC_DLY: begin
				if (!bc_s) begin
					next_bc_state = LNBSC_BC_NORM;
					next_bc_cnt = '0;
				end else if (sw_tick) begin
					next_bc_cnt = bc_dly_end ? '0 : bc_inc;
					if (bc_dly_end) begin
						next_bc_state = LNBSC_BC_OFF;
					end
				end
			end
			LNBSC_BC_OFF: begin
				if (sw_tick) begin
					next_bc_cnt = bc_off_end ? '0 : bc_inc;
					if (bc_off_end) begin
						next_bc_state = bc_s ?
							LNBSC_BC_DLY : LNBSC_BC_NORM;
					end
				end
			end
			default: begin
				next_bc_state = LNBSC_BC_NORM;
				next_bc_cnt = '0;
			end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bc_state <= LNBSC_BC_NORM;
			bc_cnt <= '0;
		end else begin
			bc_state <= next_bc_state;
			bc_cnt <= next_bc_cnt;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Flags cleared before start-up so software sees them low
	always_ff @(posedge ref_clk) begin
		if (!nrst || uvlo_s) begin
			ot_flag <= 1'b0;
			ol_flag <= 1'b0;
			bc_flag <= 1'b0;
		end else begin
			ot_flag <= ot_s || (ot_flag && !cool2);
			if (!enable_bit) begin
				ol_flag <= 1'b0;
			end else if (static_limit_select_bit) begin
				ol_flag <= clamp_s;
			end else if (next_ol_state == LNBSC_OL_OFF) begin
				ol_flag <= 1'b1;
			end else if (next_ol_state == LNBSC_OL_NORM) begin
				ol_flag <= 1'b0;
			end
			if (!enable_bit) begin
				bc_flag <= 1'b0;
			end else if (next_bc_state == LNBSC_BC_OFF) begin
				bc_flag <= 1'b1;
			end else if (next_bc_state == LNBSC_BC_NORM) begin
				bc_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire power_on = alive && !ot_flag && (ol_state != LNBSC_OL_OFF)
		&& (bc_state != LNBSC_BC_OFF);
	wire [1:0] pin_code = range_s ? {1'b1, upper_range_step_bit}
		: {1'b0, lower_range_step_bit};
	wire [1:0] bit_code = {upper_range_step_bit, lower_range_step_bit};
	wire [1:0] sel_code = range_pin_disable_bit ? bit_code : pin_code;
	wire burst_tone = int_tone && mod_s;
	wire mux_tone = tone_on_bit ? int_tone
		: ext_tone_pass_select ? mod_s : burst_tone;
	wire tone_seen = thr_s ? det_tx_s : det_rx_s;
	wire any_fault = ot_flag || ol_flag || bc_flag || uvlo_s
		|| sreset_s;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			converter_en <= 1'b0;
			linreg_en <= 1'b0;
			current_limited <= 1'b0;
			dynamic_limit_en <= 1'b0;
			limit_level <= 2'h0;
			vout_code <= VOUT_13V3;
			tone_out <= 1'b0;
			sw_clk <= 1'b0;
			tone_detected_oe <= 1'b0;
			fault_indicator_oe <= 1'b1;
		end else begin
			converter_en <= power_on;
			linreg_en <= power_on;
			current_limited <= (ol_state == LNBSC_OL_ON);
			dynamic_limit_en <= !static_limit_select_bit;
			limit_level <= {limit_level_msb, limit_level_lsb};
			vout_code <= sel_code;
			tone_out <= power_on && mux_tone;
			sw_clk <= power_on && osc_clk;
			tone_detected_oe <= tone_seen;
			fault_indicator_oe <= any_fault;
		end
	end

	// Open-drain pins only ever drive low
	always_ff @(posedge ref_clk) begin
		tone_detected_n <= 1'b0;
		fault_indicator_n <= 1'b0;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_uvlo_off;
		uvlo_s |=> !converter_en && !linreg_en;
	endproperty
	a_uvlo_off: assert property (p_uvlo_off)
		else $error("output on during lockout");

	property p_shutdown;
		!enable_bit |=> !converter_en ##0 !tone_out;
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("output on while disabled");

	property p_tone_cont;
		(tone_on_bit && power_on) |=> tone_out == $past(int_tone);
	endproperty
	a_tone_cont: assert property (p_tone_cont)
		else $error("continuous tone wrong");

	property p_burst;
		(!tone_on_bit && !ext_tone_pass_select)
			|=> tone_out == $past(power_on && int_tone && mod_s);
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst tone wrong");

	property p_ext_pass;
		(!tone_on_bit && ext_tone_pass_select && power_on)
			|=> tone_out == $past(mod_s);
	endproperty
	a_ext_pass: assert property (p_ext_pass)
		else $error("external tone not passed");

	property p_vout;
		1'b1 |=> vout_code == $past(range_pin_disable_bit ?
			{upper_range_step_bit, lower_range_step_bit} :
			(range_s ? {1'b1, upper_range_step_bit} :
			{1'b0, lower_range_step_bit}));
	endproperty
	a_vout: assert property (p_vout)
		else $error("output voltage code wrong");

	property p_ol_set;
		(ol_state == LNBSC_OL_DLY ##1 ol_state == LNBSC_OL_OFF)
			|-> ol_flag ##1 !converter_en;
	endproperty
	a_ol_set: assert property (p_ol_set)
		else $error("overload shutdown wrong");

	property p_static;
		(static_limit_select_bit && enable_bit && !uvlo_s)
			|=> ol_flag == $past(clamp_s);
	endproperty
	a_static: assert property (p_static)
		else $error("static flag wrong");

	property p_ot;
		ot_s |=> ot_flag && !enable_bit && cfg_tone == 2'h0;
	endproperty
	a_ot: assert property (p_ot)
		else $error("over-temperature not handled");

	property p_detect;
		1'b1 |=> tone_detected_oe == $past(thr_s ? det_tx_s : det_rx_s);
	endproperty
	a_detect: assert property (p_detect)
		else $error("tone detect wrong");

	property p_fault;
		(ol_flag || bc_flag || ot_flag) |=> fault_indicator_oe;
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault pin not pulled");
endmodule // lnbsc_ctrl

// File: lnbsc_host.sv
// Host model: register bus master of the supply control block
`timescale 1ns/1ns
module lnbsc_host (
	// Clock
	input wire logic ref_clk,
	// Avalon-MM master
	output logic [3:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	// ----------------------------------------
	// Bus cycle
	// ----------------------------------------
	bit stuck;
	initial begin
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
	end
	// Request held until waitrequest is sampled low, then one idle edge
	task automatic xfer(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		begin
			n = 0;
			address <= a;
			writedata <= d;
			write <= wr;
			read <= !wr;
			do begin
				@(posedge ref_clk);
				n++;
			end while (waitrequest !== 1'b0 && n < 50);
			q = readdata;
			stuck = (waitrequest !== 1'b0);
			write <= 1'b0;
			read <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
endmodule // lnbsc_host

// File: lnbsc_tb.sv
// Self-checking bench of the supply control block
`timescale 1ns/1ns
module testbench;
	import lnbsc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic ref_clk = 1'b0, nrst = 1'b0;
	logic [3:0] address;
	logic read, write, waitrequest;
	logic [31:0] writedata, readdata;
	logic uvlo = 0, mod = 0, thr = 0, td_rx = 0, td_tx = 0, pin = 0;
	logic ovl = 0, clamp = 0, bc = 0, ot = 0, cool = 1, sres = 0;
	logic sw_clk, conv_en, lin_en, cur_lim, dyn_en, tone_out;
	logic [1:0] lvl, vout;
	logic td_n, td_oe, flt_n, flt_oe;
	int error_cnt = 0, checks = 0, seed = 67056, c;
	logic [31:0] v;
	always #50 ref_clk = ~ref_clk;
	lnbsc_ctrl #(.OFF_T(20), .ON_T(10), .BC_OFF_T(8)) lnbsc_ctrl_i (
		.ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .uvlo(uvlo),
		.tone_modulation_input(mod), .detector_threshold_select(thr),
		.tone_detector_input(td_rx), .tone_over_tx_level(td_tx),
		.range_select_pin(pin), .overload_sense(ovl), .clamp_sense(clamp),
		.back_current_sense(bc), .over_temp_sense(ot),
		.cooled_sense(cool), .serial_reset(sres), .sw_clk(sw_clk),
		.converter_en(conv_en), .linreg_en(lin_en),
		.current_limited(cur_lim), .dynamic_limit_en(dyn_en),
		.limit_level(lvl), .vout_code(vout), .tone_out(tone_out),
		.tone_detected_n(td_n), .tone_detected_oe(td_oe),
		.fault_indicator_n(flt_n), .fault_indicator_oe(flt_oe));
	lnbsc_host lnbsc_host_i (.ref_clk(ref_clk), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest));
	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		lnbsc_host_i.xfer(1'b1, a, d, q);
		if (lnbsc_host_i.stuck) begin
			error_cnt++;
			finish_test();
		end
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		lnbsc_host_i.xfer(1'b0, a, 32'h0, q);
		if (lnbsc_host_i.stuck) begin
			error_cnt++;
			finish_test();
		end else
			check(q, e);
	endtask
	// Bounded wait on converter_en (0) or current_limited (1)
	task automatic wait_for(input int s, input logic val, input int lim);
		int n;
		logic x;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			x = s ? cur_lim : conv_en;
		end while (x !== val && n < lim);
		check(x, val);
		if (x !== val)
			finish_test();
	endtask
	task automatic count(input int n, input int which, output int k);
		logic p;
		k = 0;
		p = which ? sw_clk : tone_out;
		repeat (n) begin
			@(posedge ref_clk);
			if ((which ? sw_clk : tone_out) !== p && !p)
				k++;
			p = which ? sw_clk : tone_out;
		end
	endtask
	task automatic done(input string name);
		$display("test %s done at %0t", name, $time);
	endtask
	function automatic logic [1:0] vexp(logic rpd, up, lo, p);
		return rpd ? {up, lo} : (p ? {1'b1, up} : {1'b0, lo});
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cyc(5);
		nrst <= 1'b1;
		cyc(3);
		rdc(REG_STAT, 32'h0);
		rdc(REG_CTRL, 32'h0);
		rdc(4'h2, 32'h0);
		check(conv_en, 1'b0);
		wr(REG_CTRL, 32'h4);
		cyc(6);
		check({conv_en, lin_en, flt_oe}, 3'h6);
		wr(REG_STAT, 32'hff);
		rdc(REG_STAT, 32'h8);
		count(440, 1, c);
		check(c >= 19 && c <= 21, 1'b1);
		done("basic");
		for (int i = 0; i < 6; i++) begin
			v = 32'($random(seed)) & 32'hf;
			wr(REG_CMD, v);
			rdc(REG_CMD, v);
			check({dyn_en, lvl}, {!v[3], v[1:0]});
		end
		for (int i = 0; i < 16; i++) begin
			wr(REG_CMD, 32'(i[3]) << 2);
			wr(REG_CTRL, {29'h0, 1'b1, i[2:1]});
			pin <= i[0];
			cyc(5);
			check(vout, vexp(i[3], i[2], i[1], i[0]));
		end
		done("range");
		wr(REG_TONE, 32'h1);
		mod <= 1'($random(seed));
		count(1000, 0, c);
		check(c >= 2, 1'b1);
		// Tone bit kept clear while bursting on the pin
		wr(REG_TONE, 32'h0);
		mod <= 1'b0;
		cyc(4);
		count(1000, 0, c);
		check(c, 32'h0);
		mod <= 1'b1;
		count(1000, 0, c);
		check(c >= 2, 1'b1);
		wr(REG_TONE, 32'h2);
		for (int i = 0; i < 4; i++) begin
			mod <= i[0];
			cyc(5);
			check(tone_out, i[0]);
		end
		for (int i = 0; i < 8; i++) begin
			{thr, td_rx, td_tx} <= 3'($random(seed));
			cyc(5);
			check(td_oe, thr ? td_tx : td_rx);
		end
		done("tone");
		// Dynamic limiting; a static start first eases capacitive loads
		wr(REG_CMD, 32'h8);
		clamp <= 1'b1;
		cyc(6);
		rdc(REG_STAT, 32'ha);
		clamp <= 1'b0;
		cyc(6);
		rdc(REG_STAT, 32'h8);
		wr(REG_CMD, 32'h0);
		ovl <= 1'b1;
		cyc(200);
		check(conv_en, 1'b1);
		wait_for(0, 1'b0, 200);
		rdc(REG_STAT, 32'h2);
		check(flt_oe, 1'b1);
		cyc(400);
		check({conv_en, cur_lim}, 2'h0);
		wait_for(1, 1'b1, 100);
		wait_for(0, 1'b0, 300);
		ovl <= 1'b0;
		wait_for(1, 1'b1, 600);
		wait_for(1, 1'b0, 300);
		cyc(3);
		rdc(REG_STAT, 32'h8);
		done("overload");
		bc <= 1'b1;
		cyc(900);
		check(conv_en, 1'b1);
		wait_for(0, 1'b0, 300);
		rdc(REG_STAT, 32'h1);
		wait_for(0, 1'b1, 400);
		wait_for(0, 1'b0, 1200);
		bc <= 1'b0;
		wait_for(0, 1'b1, 400);
		cyc(3);
		rdc(REG_STAT, 32'h8);
		done("back current");
		{ot, cool} <= 2'h2;
		cyc(6);
		check({conv_en, lin_en}, 2'h0);
		rdc(REG_STAT, 32'h4);
		wr(REG_CTRL, 32'h4);
		rdc(REG_CTRL, 32'h0);
		{ot, cool} <= 2'h1;
		cyc(6);
		rdc(REG_STAT, 32'h0);
		wr(REG_CTRL, 32'h4);
		wait_for(0, 1'b1, 10);
		done("thermal");
		uvlo <= 1'b1;
		cyc(6);
		check({conv_en, flt_oe}, 2'h1);
		rdc(REG_CTRL, 32'h0);
		uvlo <= 1'b0;
		cyc(6);
		check(flt_oe, 1'b0);
		sres <= 1'b1;
		cyc(5);
		check(flt_oe, 1'b1);
		check({td_n, flt_n}, 2'h0);
		done("lockout");
		finish_test();
	end
endmodule // testbench
